// ===== hdl/smbus_config_pkg.sv
// constants, register map and state codes for the smbus configuration byte bank
package smbus_config_pkg;

    localparam logic [7:0] OFS_EDGE_RATE = 8'h03;
    localparam logic [7:0] OFS_RESERVED = 8'h04;
    localparam logic [7:0] OFS_REVISION_VENDOR = 8'h05;
    localparam logic [7:0] OFS_CATEGORY_DEVICE = 8'h06;
    localparam logic [7:0] OFS_READ_LENGTH = 8'h07;

    // byte 3 reserved bits read as their fixed pattern, bit 0 is live
    localparam logic [7:0] EDGE_RATE_FIXED = 8'hC2;
    localparam logic EDGE_SEL_RESET = 1'b1;
    localparam logic [7:0] RESERVED_READ = 8'hFF;
    localparam int READ_LENGTH_WIDTH = 5;
    localparam logic [4:0] READ_LENGTH_RESET = 5'h08;
    localparam logic [2:0] READ_LENGTH_PAD = 3'h0;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    localparam logic [7:0] PTR_RESET = 8'h00;

    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_TX_BIT = 4'h7;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b000_0001,
        ST_ADDR = 7'b000_0010,
        ST_ADDR_ACK = 7'b000_0100,
        ST_RX = 7'b000_1000,
        ST_RX_ACK = 7'b001_0000,
        ST_TX = 7'b010_0000,
        ST_TX_ACK = 7'b100_0000
    } state_t;

    typedef enum logic [1:0] {
        RX_INDEX = 2'h0,
        RX_COUNT = 2'h1,
        RX_DATA = 2'h2
    } rx_phase_t;

endpackage

// ===== hdl/smbus_config_id_bytes.sv
// smbus slave giving access to configuration bytes 3 to 7 of the clock buffer
`timescale 1ns/1ns
module smbus_config_id_bytes
    import smbus_config_pkg::*;
#(
    parameter logic [3:0] SILICON_REVISION = 4'h3, // arbitrary value
    parameter logic [3:0] MAKER_CODE = 4'h9, // arbitrary value
    parameter logic [1:0] DEVICE_CATEGORY = 2'h2, // arbitrary value
    parameter logic [5:0] DEVICE_CODE = 6'h2A // arbitrary value
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [6:0] device_address_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    output logic output4_edge_speed_select_out,
    output logic [4:0] read_length_out
);

    function automatic logic [7:0] read_byte(input logic [7:0] idx, input logic sel,
                                             input logic [4:0] len);
        logic [7:0] val;
        val = UNMAPPED_READ;
        unique case (idx)
            OFS_EDGE_RATE: val = EDGE_RATE_FIXED | {7'h00, sel};
            OFS_RESERVED: val = RESERVED_READ;
            OFS_REVISION_VENDOR: val = {SILICON_REVISION, MAKER_CODE};
            OFS_CATEGORY_DEVICE: val = {DEVICE_CATEGORY, DEVICE_CODE};
            OFS_READ_LENGTH: val = {READ_LENGTH_PAD, len};
            default: val = UNMAPPED_READ;
        endcase
        return val;
    endfunction

    // pin synchronisers; stage 1 feeds stage 2 only
    logic [SYNC_STAGES-1:0] scl_sync_reg;
    logic [SYNC_STAGES-1:0] sda_sync_reg;
    logic scl_f_reg;
    logic sda_f_reg;
    logic scl_f_next;
    logic sda_f_next;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scl_sync_reg <= '1;
            sda_sync_reg <= '1;
            scl_f_reg <= 1'b1;
            sda_f_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[SYNC_STAGES-2:0], scl_in};
            sda_sync_reg <= {sda_sync_reg[SYNC_STAGES-2:0], sda_in};
            scl_f_reg <= scl_f_next;
            sda_f_reg <= sda_f_next;
        end
    end

    // a level counts only once stages two and three agree
    always_comb begin
        scl_f_next = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_f_reg;
        sda_f_next = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_f_reg;
    end

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    always_comb begin
        scl_rise = scl_f_next & ~scl_f_reg;
        scl_fall = ~scl_f_next & scl_f_reg;
        bus_start = scl_f_reg & scl_f_next & sda_f_reg & ~sda_f_next;
        bus_stop = scl_f_reg & scl_f_next & ~sda_f_reg & sda_f_next;
    end

    state_t state_reg;
    state_t state_next;
    logic [3:0] bit_cnt_reg;
    logic [3:0] bit_cnt_next;
    logic [7:0] shift_reg;
    logic [7:0] shift_next;
    logic [7:0] ptr_reg;
    logic [7:0] ptr_next;
    rx_phase_t phase_reg;
    rx_phase_t phase_next;
    logic read_mode_reg;
    logic read_mode_next;
    logic sda_oe_reg;
    logic sda_oe_next;
    logic edge_sel_reg;
    logic edge_sel_next;
    logic [4:0] len_reg;
    logic [4:0] len_next;

    always_comb begin
        logic [7:0] tx_byte;
        tx_byte = read_byte(ptr_reg, edge_sel_reg, len_reg);
        state_next = state_reg;
        bit_cnt_next = bit_cnt_reg;
        shift_next = shift_reg;
        ptr_next = ptr_reg;
        phase_next = phase_reg;
        read_mode_next = read_mode_reg;
        sda_oe_next = sda_oe_reg;
        edge_sel_next = edge_sel_reg;
        len_next = len_reg;
        if (bus_stop) begin
            state_next = ST_IDLE;
            sda_oe_next = 1'b0;
        end else if (bus_start) begin
            // repeated start keeps the index written before it
            state_next = ST_ADDR;
            bit_cnt_next = 4'h0;
            sda_oe_next = 1'b0;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    sda_oe_next = 1'b0;
                end
                ST_ADDR, ST_RX: begin
                    if (scl_rise && bit_cnt_reg != BITS_PER_BYTE) begin
                        shift_next = {shift_reg[6:0], sda_f_next};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end
                    if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == device_address_in) begin
                                state_next = ST_ADDR_ACK;
                                sda_oe_next = 1'b1;
                                read_mode_next = shift_reg[0];
                                phase_next = RX_INDEX;
                            end else begin
                                state_next = ST_IDLE;
                            end
                        end else begin
                            state_next = ST_RX_ACK;
                            sda_oe_next = 1'b1;
                            unique case (phase_reg)
                                RX_INDEX: begin
                                    ptr_next = shift_reg;
                                    phase_next = RX_COUNT;
                                end
                                RX_COUNT: begin
                                    phase_next = RX_DATA;
                                end
                                RX_DATA: begin
                                    if (ptr_reg == OFS_EDGE_RATE) begin
                                        edge_sel_next = shift_reg[0];
                                    end
                                    if (ptr_reg == OFS_READ_LENGTH) begin
                                        len_next = shift_reg[READ_LENGTH_WIDTH-1:0];
                                    end
                                    ptr_next = ptr_reg + 8'h01;
                                end
                                default: phase_next = RX_DATA;
                            endcase
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        if (read_mode_reg) begin
                            // the length byte leads every block read
                            shift_next = {READ_LENGTH_PAD, len_reg};
                            // the top pad bit leads the length byte, so its first bit pulls low
                            sda_oe_next = ~READ_LENGTH_PAD[2];
                            state_next = ST_TX;
                        end else begin
                            sda_oe_next = 1'b0;
                            state_next = ST_RX;
                        end
                    end
                end
                ST_RX_ACK: begin
                    if (scl_fall) begin
                        sda_oe_next = 1'b0;
                        bit_cnt_next = 4'h0;
                        state_next = ST_RX;
                    end
                end
                ST_TX: begin
                    if (scl_fall) begin
                        if (bit_cnt_reg == LAST_TX_BIT) begin
                            sda_oe_next = 1'b0;
                            state_next = ST_TX_ACK;
                        end else begin
                            bit_cnt_next = bit_cnt_reg + 4'h1;
                            shift_next = {shift_reg[6:0], 1'b0};
                            sda_oe_next = ~shift_reg[6];
                        end
                    end
                end
                ST_TX_ACK: begin
                    if (scl_rise && sda_f_next) begin
                        state_next = ST_IDLE;
                    end else if (scl_fall) begin
                        shift_next = tx_byte;
                        ptr_next = ptr_reg + 8'h01;
                        sda_oe_next = ~tx_byte[7];
                        bit_cnt_next = 4'h0;
                        state_next = ST_TX;
                    end
                end
                default: begin
                    state_next = ST_IDLE;
                    sda_oe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg <= ST_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= PTR_RESET;
            phase_reg <= RX_INDEX;
            read_mode_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            edge_sel_reg <= EDGE_SEL_RESET;
            len_reg <= READ_LENGTH_RESET;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            ptr_reg <= ptr_next;
            phase_reg <= phase_next;
            read_mode_reg <= read_mode_next;
            sda_oe_reg <= sda_oe_next;
            edge_sel_reg <= edge_sel_next;
            len_reg <= len_next;
        end
    end

    // open drain: the pin value is always low, only the enable moves
    logic sda_low_reg;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sda_low_reg <= 1'b0;
        end else begin
            sda_low_reg <= 1'b0;
        end
    end

    assign sda_out = sda_low_reg;
    assign sda_oe_out = sda_oe_reg;
    assign output4_edge_speed_select_out = edge_sel_reg;
    assign read_length_out = len_reg;

endmodule // smbus_config_id_bytes

// ===== verif/smbus_config_checker.sv
// concurrent checks on the smbus configuration bank pins
`timescale 1ns/1ns
module smbus_config_checker (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_out,
    input wire logic output4_edge_speed_select_out,
    input wire logic [4:0] read_length_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_scl_high; scl_in [*6]; endsequence
    sequence s_oe_held; sda_oe_out [*4]; endsequence
    a_reset_values: assert property (
        $rose(rst_n_in) |-> output4_edge_speed_select_out && read_length_out == 5'h08)
        else $error("bad value after reset");
    a_data_low: assert property (
        !sda_out) else $error("data pin driven high");
    a_edge_scl_low: assert property (
        $changed(output4_edge_speed_select_out) |-> !scl_in) else $error("edge moved");
    a_len_scl_low: assert property (
        $changed(read_length_out) |-> !scl_in) else $error("length moved");
    a_oe_rise_low: assert property (
        $rose(sda_oe_out) |-> !scl_in) else $error("data pull with clock high");
    a_oe_held_on: assert property (
        $rose(sda_oe_out) |=> s_oe_held) else $error("data pull too short");
    a_oe_steady_high: assert property (
        s_scl_high |-> $stable(sda_oe_out)) else $error("data moved under clock high");
    a_len_edge_apart: assert property (
        $changed(read_length_out) |-> $stable(output4_edge_speed_select_out))
        else $error("two registers moved together");
endmodule // smbus_config_checker

bind smbus_config_id_bytes smbus_config_checker smbus_config_checker_inst (.clk_in, .rst_n_in,
    .scl_in, .sda_out, .sda_oe_out, .output4_edge_speed_select_out, .read_length_out);

// ===== verif/smbus_host_model.sv
// smbus host controller model that drives the clock and data pins
`timescale 1ns/1ns
module smbus_host_model (
    input wire logic clk_in,
    input wire logic sda_wire_in,
    output logic scl_out,
    output logic sda_out
);
    logic nack_seen;
    initial {scl_out, sda_out, nack_seen} = 3'b110;
    // six cycles a step keeps scl low well above the slave's minimum
    task automatic st(input logic c, input logic d);
        scl_out = c;
        sda_out = d;
        repeat (6) @(negedge clk_in);
    endtask
    // data moves only with scl low, then flips under scl high: 1 frames a start, 0 a stop
    task automatic frame(input logic v);
        st(1'b0, sda_out);
        st(1'b0, v);
        st(1'b1, v);
        st(1'b1, ~v);
    endtask
    task automatic xfer(input logic [8:0] d, output logic [8:0] r);
        for (int i = 8; i >= 0; i--) begin
            st(1'b0, sda_out);
            st(1'b0, d[i]);
            st(1'b1, d[i]);
            r[i] = sda_wire_in;
            st(1'b1, d[i]);
        end
    endtask
    // n below zero writes -n bytes d, d+1, ... from index i, otherwise a block read of n bytes
    task automatic run(input logic [6:0] a, input logic [7:0] i, input logic [7:0] d,
        input int n, output logic [7:0] got [$]);
        logic [8:0] r;
        got = {};
        frame(1'b1);
        xfer({a, 2'b01}, r);
        nack_seen = r[0];
        xfer({i, 1'b1}, r);
        if (n < 0) begin
            xfer({8'(-n), 1'b1}, r);
            for (int k = 0; k < -n; k++) begin
                xfer({d + 8'(k), 1'b1}, r);
            end
        end else begin
            frame(1'b1);
            xfer({a, 2'b11}, r);
            for (int k = 0; k <= n; k++) begin
                xfer({8'hFF, k == n}, r);
                got.push_back(r[8:1]);
            end
        end
        frame(1'b0);
    endtask
endmodule // smbus_host_model

// ===== verif/testbench.sv
// self-checking bench for the smbus configuration bank
`timescale 1ns/1ns
module testbench;
    localparam logic [6:0] DEV = 7'h52;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic scl, sda_host, sda_oe, sda_o, edge_sel;
    logic [4:0] len;
    wire logic sda_wire = sda_host & ~sda_oe;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000_52DF;
    logic [7:0] mdl [8];
    logic [7:0] got [$];
    smbus_config_id_bytes smbus_config_id_bytes_inst (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .device_address_in(DEV), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .output4_edge_speed_select_out(edge_sel), .read_length_out(len));
    smbus_host_model smbus_host_model_inst (.clk_in(clk_in), .sda_wire_in(sda_wire),
        .scl_out(scl), .sda_out(sda_host));
    initial forever #5 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 60000) begin
            mismatches++;
            stop_test;
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic pins;
        check("edge", {7'h00, edge_sel}, {7'h00, mdl[3][0]});
        check("length", {3'h0, len}, mdl[7]);
    endtask
    task automatic write(input logic [7:0] i, input logic [7:0] d);
        smbus_host_model_inst.run(DEV, i, d, -1, got);
        if (i == 8'h03) mdl[3] = {7'h61, d[0]};
        if (i == 8'h07) mdl[7] = {3'h0, d[4:0]};
        check("ack", {7'h00, smbus_host_model_inst.nack_seen}, 8'h00);
        pins;
    endtask
    task automatic rd_chk(input logic [7:0] i, input int n);
        logic [7:0] idx;
        logic [7:0] want;
        smbus_host_model_inst.run(DEV, i, 8'h00, n, got);
        check("count", got[0], mdl[7]);
        for (int k = 1; k <= n; k++) begin
            // eight bits, so the index wraps the same way the device pointer does
            idx = i + 8'(k - 1);
            want = (idx >= 8'h03 && idx <= 8'h07) ? mdl[idx[2:0]] : 8'h00;
            check("byte", got[k], want);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        mdl = '{8'h00, 8'h00, 8'h00, 8'hC3, 8'hFF, 8'h39, 8'hAA, 8'h08};
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        pins;
        rd_chk(8'h03, 5);
        $display("reset value test done");
        for (int i = 3; i <= 7; i++) begin
            seed = xs(seed);
            write(8'(i), seed[7:0]);
        end
        write(8'h03, 8'h00);
        rd_chk(8'h02, 7);
        write(8'h03, 8'hFF);
        $display("register write test done");
        // a foreign address must leave the length alone
        smbus_host_model_inst.run(DEV ^ 7'h01, 8'h07, 8'h1F, -1, got);
        check("nack", {7'h00, smbus_host_model_inst.nack_seen}, 8'h01);
        pins;
        // one write of two bytes: index 6 ignores its byte, index 7 takes the next
        smbus_host_model_inst.run(DEV, 8'h06, 8'h13, -2, got);
        mdl[7] = 8'h14;
        check("ack", {7'h00, smbus_host_model_inst.nack_seen}, 8'h00);
        pins;
        rd_chk(8'hFE, 9);
        $display("address and wrap test done");
        for (int t = 0; t < 6; t++) begin
            seed = xs(seed);
            write(8'h02 + 8'(seed[2:0]), seed[15:8]);
            rd_chk(8'h02 + 8'(seed[18:16]), 2);
        end
        $display("random test done");
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        mdl[3] = 8'hC3;
        mdl[7] = 8'h08;
        repeat (4) @(negedge clk_in);
        pins;
        rd_chk(8'h07, 1);
        $display("second reset test done");
        stop_test;
    end
endmodule // testbench
